// File: core/serial_fuse_ctrl.sv
// Serial port configuration and fuse memory integrity check control.
// Assumes register requests and fuse memory contents on the local clock,
// and two-wire bus pins arriving from outside, resynchronised here.
`timescale 1ns/10ps

// Functional notes
// RULE_01: Filter bypass bit set disables the two-wire input glitch filter.
// RULE_02: Four-wire build variant keeps the glitch filter disabled regardless.
// RULE_03: High-speed bit selects 10 ns filter width instead of 50 ns.
// RULE_04: Slow-fall bit drives the data line with a slower falling slope.
// RULE_05: Route select bit puts the sample ready signal onto output pin zero.
// RULE_06: Setting ECC bit starts fuse ECC check, error reported in status.
// RULE_07: Setting CRC bit starts fuse CRC check, error reported in status.
// RULE_08: With both check bits clear the fuse controller stays idle.
// RULE_09: Both configuration registers reset to all zero.
// RULE_10: Reserved bits four to one read zero and ignore writes.
module serial_fuse_ctrl
#(
    parameter bit FOUR_WIRE_VARIANT = 1'b0
)
(
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              resetn,
    // Register port from the serial host logic
    input  wire serial_fuse_pkg::reg_req_t         reg_req,
    output serial_fuse_pkg::reg_rsp_t              reg_rsp,
    // Two-wire bus pins
    input  wire logic                              scl_in,
    input  wire logic                              sda_in,
    input  wire logic                              sda_drive_low,
    output logic                                   scl_filtered,
    output logic                                   sda_filtered,
    output logic                                   sda_out,
    output logic                                   sda_oe,
    output logic                                   sda_slow_fall,
    // Output pin zero
    input  wire logic                              sample_ready_signal,
    input  wire logic                              audio_out_data,
    output logic                                   audio_out_pin_zero,
    // Fuse memory contents and check status
    input  wire logic [serial_fuse_pkg::FUSE_WORDS*serial_fuse_pkg::FUSE_WIDTH-1:0] fuse_image,
    output serial_fuse_pkg::status_word_two_t      status_word_two
);
    import serial_fuse_pkg::*;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] serial_port_ready_config;
    logic [7:0] fuse_check_control;
    wire        hit_serial = reg_req.addr == SERIAL_PORT_READY_CONFIG_OFFSET;
    wire        hit_fuse   = reg_req.addr == FUSE_CHECK_CONTROL_OFFSET;
    wire        write_serial = reg_req.write && hit_serial;
    wire        write_fuse   = reg_req.write && hit_fuse;
    wire [7:0]  next_serial_port_ready_config =
        reg_req.wdata & SERIAL_PORT_WRITE_MASK; // RULE_10

    logic       check_done;
    logic [7:0] next_fuse_check_control;

    // A write landing in the same cycle as completion wins over the clear.
    always_comb
    begin
        next_fuse_check_control = fuse_check_control;
        if (check_done)
        begin
            next_fuse_check_control[FUSE_ECC_CHECK_BIT] = 1'b0;
            next_fuse_check_control[FUSE_CRC_CHECK_BIT] = 1'b0;
        end
        if (write_fuse)
        begin
            next_fuse_check_control = reg_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            serial_port_ready_config <= SERIAL_PORT_READY_CONFIG_RESET; // RULE_09
            fuse_check_control       <= FUSE_CHECK_CONTROL_RESET; // RULE_09
        end
        else
        begin
            if (write_serial)
            begin
                serial_port_ready_config <= next_serial_port_ready_config;
            end
            fuse_check_control <= next_fuse_check_control;
        end
    end

    // ------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------
    wire [7:0] read_mux = hit_serial ? serial_port_ready_config :
                          hit_fuse   ? fuse_check_control : 8'h00;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rsp <= '0;
        end
        else
        begin
            reg_rsp.valid <= reg_req.read;
            reg_rsp.rdata <= reg_req.read ? read_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Glitch filter
    // ------------------------------------------------------------
    wire filter_off = FOUR_WIRE_VARIANT ||
                      serial_port_ready_config[FILTER_BYPASS_BIT]; // RULE_01 RULE_02
    wire [2:0] filter_limit = serial_port_ready_config[HIGH_SPEED_ENABLE_BIT] ?
                              FILTER_HIGH_CYCLES : FILTER_STANDARD_CYCLES; // RULE_03
    wire [1:0] pin_raw = {sda_in, scl_in};
    logic [1:0] pin_clean;

    // A change must persist for the whole filter width before it passes;
    // shorter pulses are swallowed, adding one clock cycle less than that width as latency.
    genvar line;
    generate
        for (line = 0; line < 2; line++)
        begin : g_filter
            logic       sync_a;
            logic       sync_b;
            logic [2:0] stable_count;
            wire        differs = sync_b != pin_clean[line];
            wire [2:0]  next_count = stable_count + 3'h1;

            always_ff @(posedge clock or negedge resetn)
            begin
                if (!resetn)
                begin
                    sync_a       <= 1'b1;
                    sync_b       <= 1'b1;
                    stable_count <= 3'h0;
                    pin_clean[line] <= 1'b1;
                end
                else
                begin
                    sync_a <= pin_raw[line];
                    sync_b <= sync_a;
                    if (filter_off) // RULE_01
                    begin
                        pin_clean[line] <= sync_b;
                        stable_count    <= 3'h0;
                    end
                    else if (!differs)
                    begin
                        stable_count <= 3'h0;
                    end
                    else if (next_count >= filter_limit) // RULE_03
                    begin
                        pin_clean[line] <= sync_b;
                        stable_count    <= 3'h0;
                    end
                    else
                    begin
                        stable_count <= next_count;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    wire next_pin_zero = serial_port_ready_config[READY_ROUTE_SELECT_BIT] ?
                         sample_ready_signal : audio_out_data; // RULE_05

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_filtered       <= 1'b1;
            sda_filtered       <= 1'b1;
            sda_out            <= 1'b0;
            sda_oe             <= 1'b0;
            sda_slow_fall      <= 1'b0;
            audio_out_pin_zero <= 1'b0;
        end
        else
        begin
            scl_filtered       <= pin_clean[0];
            sda_filtered       <= pin_clean[1];
            sda_out            <= 1'b0;
            sda_oe             <= sda_drive_low;
            sda_slow_fall      <= serial_port_ready_config[SDA_SLOW_FALL_BIT]; // RULE_04
            audio_out_pin_zero <= next_pin_zero; // RULE_05
        end
    end

    // ------------------------------------------------------------
    // Fuse integrity checker
    // ------------------------------------------------------------
    // ECC here is one even parity bit per word: it catches single flips but
    // cannot correct them, which is enough for a go/no-go status flag.
    logic [FUSE_WIDTH-1:0] fuse_word [FUSE_WORDS];
    fuse_state_t state;
    fuse_state_t next_state;
    logic [3:0]  word_index;
    logic [7:0]  crc_value;
    logic        ecc_error;
    logic        crc_error;

    genvar w;
    generate
        for (w = 0; w < FUSE_WORDS; w++)
        begin : g_fuse
            assign fuse_word[w] = fuse_image[w*FUSE_WIDTH +: FUSE_WIDTH];
        end
    endgenerate

    function automatic logic [7:0] crc_step(input logic [7:0] crc,
                                            input logic [15:0] data);
        logic [7:0] c;
        c = crc;
        for (int i = 15; i >= 0; i--)
        begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ data[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    wire start_ecc  = fuse_check_control[FUSE_ECC_CHECK_BIT];
    wire start_crc  = fuse_check_control[FUSE_CRC_CHECK_BIT];
    wire last_word  = word_index == 4'(FUSE_WORDS - 1);
    wire [15:0] current_word = fuse_word[word_index];
    wire word_bad   = ^current_word;
    wire [7:0] crc_next = crc_step(crc_value, current_word);
    wire crc_bad    = crc_value != current_word[7:0];

    always_comb
    begin
        next_state = state;
        check_done = 1'b0;
        case (state)
            FUSE_IDLE:
            begin
                if (start_ecc) // RULE_06
                begin
                    next_state = FUSE_ECC;
                end
                else if (start_crc) // RULE_07
                begin
                    next_state = FUSE_CRC;
                end
            end
            FUSE_ECC:
            begin
                if (last_word)
                begin
                    next_state = start_crc ? FUSE_CRC : FUSE_IDLE;
                    check_done = !start_crc;
                end
            end
            FUSE_CRC:
            begin
                if (last_word)
                begin
                    next_state = FUSE_IDLE;
                    check_done = 1'b1;
                end
            end
            default:
            begin
                next_state = FUSE_IDLE; // RULE_08
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state      <= FUSE_IDLE;
            word_index <= 4'h0;
            crc_value  <= CRC_SEED;
            ecc_error  <= 1'b0;
            crc_error  <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            word_index <= (state == next_state && state != FUSE_IDLE) ?
                          word_index + 4'h1 : 4'h0;
            if (state == FUSE_IDLE)
            begin
                crc_value <= CRC_SEED;
                if (start_ecc)
                begin
                    ecc_error <= 1'b0;
                end
                if (start_crc && !start_ecc)
                begin
                    crc_error <= 1'b0;
                end
            end
            else if (state == FUSE_ECC)
            begin
                ecc_error <= ecc_error | word_bad; // RULE_06
                if (last_word && start_crc)
                begin
                    crc_error <= 1'b0;
                end
            end
            else if (state == FUSE_CRC)
            begin
                if (last_word)
                begin
                    crc_error <= crc_bad; // RULE_07
                end
                else
                begin
                    crc_value <= crc_next;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            status_word_two <= '0;
        end
        else
        begin
            status_word_two.busy      <= state != FUSE_IDLE;
            status_word_two.ecc_error <= ecc_error;
            status_word_two.crc_error <= crc_error;
        end
    end

endmodule // serial_fuse_ctrl

// File: pkg/serial_fuse_pkg.sv
// Constants and carrier types for the serial port and fuse check control block.
// Assumes one 100 MHz clock and a same-clock register port from the serial host logic.
package serial_fuse_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SERIAL_PORT_READY_CONFIG_OFFSET = 8'h28;
    localparam logic [7:0] FUSE_CHECK_CONTROL_OFFSET       = 8'h29;
    localparam logic [7:0] SERIAL_PORT_READY_CONFIG_RESET  = 8'h00;
    localparam logic [7:0] FUSE_CHECK_CONTROL_RESET        = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FILTER_BYPASS_BIT      = 7;
    localparam int HIGH_SPEED_ENABLE_BIT  = 6;
    localparam int SDA_SLOW_FALL_BIT      = 5;
    localparam int READY_ROUTE_SELECT_BIT = 0;
    localparam int FUSE_ECC_CHECK_BIT     = 7;
    localparam int FUSE_CRC_CHECK_BIT     = 6;
    localparam logic [7:0] SERIAL_PORT_WRITE_MASK = 8'hE1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS    = 10;
    localparam int FILTER_STANDARD_NS = 50;
    localparam int FILTER_HIGH_NS     = 10;
    localparam logic [2:0] FILTER_STANDARD_CYCLES =
        3'((FILTER_STANDARD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [2:0] FILTER_HIGH_CYCLES =
        3'((FILTER_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    // ------------------------------------------------------------
    // Fuse memory layout
    // ------------------------------------------------------------
    localparam int FUSE_WORDS     = 16;
    localparam int FUSE_WIDTH     = 16;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'hFF;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } reg_rsp_t;

    typedef struct packed {
        logic busy;
        logic ecc_error;
        logic crc_error;
    } status_word_two_t;

    typedef enum logic [1:0] {FUSE_IDLE, FUSE_ECC, FUSE_CRC} fuse_state_t;

endpackage

// File: tb/reg_host_model.sv
// Host model that writes and reads the configuration registers.
// Assumes requests launch at the falling edge and are taken at the next rising edge.
`timescale 1ns/10ps
module reg_host_model
(
    // Clock
    input wire logic                      clock,
    // Register port
    output serial_fuse_pkg::reg_req_t     reg_req,
    input wire serial_fuse_pkg::reg_rsp_t reg_rsp
);
    import serial_fuse_pkg::*;
    initial reg_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(negedge clock);
        reg_req = '{1'b1, 1'b0, a, d};
        @(negedge clock);
        reg_req = '0;
    end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int i;
    begin
        @(negedge clock);
        reg_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clock);
        reg_req = '0;
        // A missing answer reads as unknown so it can never pass a compare.
        for (i = 0; i < 4 && reg_rsp.valid !== 1'b1; i++)
            @(negedge clock);
        d = reg_rsp.valid === 1'b1 ? reg_rsp.rdata : 8'hXX;
    end
    endtask
endmodule // reg_host_model

// File: tb/serial_fuse_ctrl_assertions.sv
// Checker of register answers, pin routing and fuse check timing.
// Assumes binding to every instance of the control block on its one clock.
`timescale 1ns/10ps
module serial_fuse_ctrl_checker
(
    // Clock and reset
    input wire logic                              clock,
    input wire logic                              resetn,
    // Watched ports
    input wire serial_fuse_pkg::reg_req_t         reg_req,
    input wire serial_fuse_pkg::reg_rsp_t         reg_rsp,
    input wire logic                              sample_ready_signal,
    input wire logic                              audio_out_pin_zero,
    input wire logic                              sda_slow_fall,
    input wire serial_fuse_pkg::status_word_two_t status_word_two
);
    import serial_fuse_pkg::*;
    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire cfg_wr = reg_req.write && reg_req.addr == SERIAL_PORT_READY_CONFIG_OFFSET;
    wire chk_wr = reg_req.write && reg_req.addr == FUSE_CHECK_CONTROL_OFFSET;
    wire start_wr = chk_wr && reg_req.wdata[7:6] != 2'h0;
    wire cfg_rd = reg_req.read && reg_req.addr == SERIAL_PORT_READY_CONFIG_OFFSET;
    wire bad_rd = reg_req.read && !cfg_rd && reg_req.addr != FUSE_CHECK_CONTROL_OFFSET;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_route_on;
        cfg_wr && reg_req.wdata[0] ##1 !cfg_wr;
    endsequence
    sequence s_check_run;
        $rose(status_word_two.busy);
    endsequence
    property p_reset_clear;
        $rose(resetn) |-> status_word_two == '0 && !sda_slow_fall && !reg_rsp.valid;
    endproperty
    property p_reserved_zero;
        cfg_rd |=> reg_rsp.valid && reg_rsp.rdata[4:1] == 4'h0;
    endproperty
    property p_unmapped_zero;
        bad_rd |=> reg_rsp.valid && reg_rsp.rdata == 8'h00;
    endproperty
    property p_slow_fall;
        cfg_wr |-> ##2 sda_slow_fall == $past(reg_req.wdata[5], 2);
    endproperty
    property p_route;
        s_route_on |-> ##1 audio_out_pin_zero == $past(sample_ready_signal);
    endproperty
    property p_ecc_start;
        chk_wr && reg_req.wdata[7] && !status_word_two.busy |-> ##[1:3] status_word_two.busy;
    endproperty
    property p_crc_start;
        chk_wr && reg_req.wdata[6] && !status_word_two.busy |-> ##[1:3] status_word_two.busy;
    endproperty
    property p_idle;
        s_check_run |-> $past(start_wr) || $past(start_wr, 2) || $past(start_wr, 3);
    endproperty
    property p_check_ends;
        s_check_run |-> ##[8:60] !status_word_two.busy;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    a_slow_fall: assert property (p_slow_fall) else $error("slow fall output wrong");
    a_route: assert property (p_route) else $error("ready not routed to pin");
    a_ecc_start: assert property (p_ecc_start) else $error("ECC check did not start");
    a_crc_start: assert property (p_crc_start) else $error("CRC check did not start");
    a_idle: assert property (p_idle) else $error("check started without request");
    a_check_ends: assert property (p_check_ends) else $error("check never finished");
endmodule // serial_fuse_ctrl_checker

bind serial_fuse_ctrl serial_fuse_ctrl_checker checker_inst
(
    .clock(clock),
    .resetn(resetn),
    .reg_req(reg_req),
    .reg_rsp(reg_rsp),
    .sample_ready_signal(sample_ready_signal),
    .audio_out_pin_zero(audio_out_pin_zero),
    .sda_slow_fall(sda_slow_fall),
    .status_word_two(status_word_two)
);

// File: tb/serial_fuse_ctrl_tb.sv
// Self-checking bench of the serial port and fuse check control block.
// Assumes the package, host model and checker are compiled before it.
`timescale 1ns/10ps
module serial_fuse_ctrl_tb;
    import serial_fuse_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e; logic s; logic p;} row_t;
    typedef struct packed {logic [7:0] cfg; logic [7:0] len; logic [7:0] e;} flt_t;
    logic             clock;
    logic             resetn;
    reg_req_t         reg_req;
    reg_rsp_t         reg_rsp;
    logic             scl_in;
    logic             scl_filtered;
    logic             sda_drive_low;
    logic             sda_out;
    logic             sda_oe;
    logic             audio_out_data;
    logic             sda_in;
    logic             sda_filtered;
    logic             sda_filtered_four;
    logic             sda_slow_fall;
    logic             sample_ready_signal;
    logic             audio_out_pin_zero;
    logic [255:0]     fuse_image;
    logic [255:0]     good;
    status_word_two_t status_word_two;
    int               n_mismatch = 0;
    int               cmp_count = 0;
    int               cycles = 0;
    logic [7:0]       d;
    logic [7:0]       lows;
    logic [7:0]       lows_four;
    logic [7:0]       lows_scl;
    row_t rows[4] = '{'{8'h28, 8'hFF, 8'hE1, 1'b1, 1'b1}, '{8'h28, 8'h1E, 8'h00, 1'b0, 1'b0},
                      '{8'h29, 8'h3F, 8'h3F, 1'b0, 1'b0}, '{8'h30, 8'h55, 8'h00, 1'b0, 1'b0}};
    flt_t flts[4] = '{'{8'h00, 8'h04, 8'h00}, '{8'h80, 8'h04, 8'h04},
                      '{8'h40, 8'h02, 8'h02}, '{8'h00, 8'h07, 8'h07}};
    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    reg_host_model reg_host_model_inst (.clock(clock), .reg_req(reg_req), .reg_rsp(reg_rsp));
    serial_fuse_ctrl serial_fuse_ctrl_inst
    (
        .clock(clock), .resetn(resetn), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .scl_in(scl_in), .sda_in(sda_in), .sda_drive_low(sda_drive_low),
        .scl_filtered(scl_filtered), .sda_filtered(sda_filtered), .sda_out(sda_out),
        .sda_oe(sda_oe), .sda_slow_fall(sda_slow_fall),
        .sample_ready_signal(sample_ready_signal), .audio_out_data(audio_out_data),
        .audio_out_pin_zero(audio_out_pin_zero), .fuse_image(fuse_image),
        .status_word_two(status_word_two)
    );
    serial_fuse_ctrl #(.FOUR_WIRE_VARIANT(1'b1)) serial_fuse_ctrl_four_inst
    (
        .clock(clock), .resetn(resetn), .reg_req(reg_req), .reg_rsp(), .scl_in(scl_in),
        .sda_in(sda_in), .sda_drive_low(sda_drive_low), .scl_filtered(),
        .sda_filtered(sda_filtered_four), .sda_out(), .sda_oe(), .sda_slow_fall(),
        .sample_ready_signal(sample_ready_signal), .audio_out_data(audio_out_data),
        .audio_out_pin_zero(), .fuse_image(fuse_image),
        .status_word_two()
    );
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test();
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    begin
        cmp_count++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
            n_mismatch++;
        end
    end
    endtask
    function automatic logic [7:0] crc_of(input logic [255:0] img);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 0; i < 240; i++)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ img[i / 16 * 16 + 15 - i % 16]) ? CRC_POLY : 8'h00);
        return c;
    endfunction
    // Holds both bus lines low for len cycles and counts low cycles on the filtered outputs.
    task automatic pulse(input logic [7:0] len);
    begin
        lows = 8'h00;
        lows_four = 8'h00;
        lows_scl = 8'h00;
        sda_in = 1'b0;
        scl_in = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            if (i == len)
            begin
                sda_in = 1'b1;
                scl_in = 1'b1;
            end
            @(negedge clock);
            lows += {7'h00, sda_filtered === 1'b0};
            lows_four += {7'h00, sda_filtered_four === 1'b0};
            lows_scl += {7'h00, scl_filtered === 1'b0};
        end
    end
    endtask
    task automatic fuse_run(input logic [7:0] cmd, input logic [255:0] img, input logic [2:0] e);
    begin
        fuse_image = img;
        reg_host_model_inst.wr(8'h29, cmd);
        for (int i = 0; i < 80; i++)
        begin
            @(negedge clock);
            if (i > 4 && status_word_two.busy === 1'b0)
                break;
        end
        chk("fuse status", {5'h00, e}, {5'h00, status_word_two});
        reg_host_model_inst.rd(8'h29, d);
        chk("fuse start bits", 8'h00, d);
    end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        resetn = 1'b0;
        sda_in = 1'b1;
        scl_in = 1'b1;
        sda_drive_low = 1'b0;
        audio_out_data = 1'b0;
        sample_ready_signal = 1'b1;
        good = '0;
        good[255:240] = {2{crc_of(good)}};
        fuse_image = good;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        chk("idle status", 8'h00, {5'h00, status_word_two});
        reg_host_model_inst.rd(8'h28, d);
        chk("config reset", 8'h00, d);
        reg_host_model_inst.rd(8'h29, d);
        chk("fuse reset", 8'h00, d);
        foreach (rows[i])
        begin
            reg_host_model_inst.wr(rows[i].a, rows[i].w);
            reg_host_model_inst.rd(rows[i].a, d);
            chk("readback", rows[i].e, d);
            chk("slow fall", {7'h00, rows[i].s}, {7'h00, sda_slow_fall});
            chk("pin zero", {7'h00, rows[i].p}, {7'h00, audio_out_pin_zero});
        end
        // With routing off the pin must follow its normal data, not a constant.
        audio_out_data = 1'b1;
        repeat (2) @(negedge clock);
        chk("pin zero audio", 8'h01, {7'h00, audio_out_pin_zero});
        sda_drive_low = 1'b1;
        @(negedge clock);
        chk("data drive", 8'h02, {6'h00, sda_oe, sda_out});
        sda_drive_low = 1'b0;
        @(negedge clock);
        chk("data release", 8'h00, {6'h00, sda_oe, sda_out});
        foreach (flts[i])
        begin
            reg_host_model_inst.wr(8'h28, flts[i].cfg);
            pulse(flts[i].len);
            chk("filtered lows", flts[i].e, lows);
            chk("four wire lows", flts[i].len, lows_four);
            chk("filtered clock lows", flts[i].e, lows_scl);
        end
        fuse_run(8'h80, good, 3'b000);
        fuse_run(8'h80, good ^ 256'h1_0000_0000_0000, 3'b010);
        // The ECC flag must stand while a CRC check runs.
        fuse_run(8'h40, good ^ {16'h0001, 240'h0}, 3'b011);
        fuse_run(8'h40, good, 3'b010);
        // Both start bits run the two checks back to back and clear both flags.
        fuse_run(8'hC0, good, 3'b000);
        reg_host_model_inst.wr(8'h28, 8'hFF);
        resetn = 1'b0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        reg_host_model_inst.rd(8'h28, d);
        chk("config after reset", 8'h00, d);
        chk("slow fall after reset", 8'h00, {7'h00, sda_slow_fall});
        stop_test();
    end
endmodule // serial_fuse_ctrl_tb
